//--- pkg/tss_pkg.sv
// How it works
// - Each sum tree reduces ten terms, two windows, two transitions, two timers to one match.
// - Every combining node is a fully programmable lookup table, any logic function.
// - Leaf inversion comes only from first-level table contents, no separate control.
// - Three sum trees per state, sixteen states, forty-eight trees in all.
// - Term gives two bits, low half and high half; hit needs both.
// - Window check gives lower-limit and upper-limit bits; in range needs both.
// - Transition and timer hits feed both inputs two and three of their table.
// - Mid tables are plain four-input gates given by sixteen table bits.
// - Final table combines both mid outputs as a two-input gate, low four bits.
// - All-zero table gives constant zero, all-ones gives constant one.
// - Tree chain is 0x40 plus four times state plus tree; six words follow.
// - Sequencer acts only on valid samples; capture tree match stores the sample.
// - Hit match increments counter; at occurrence count apply timer actions and clear counter.
// - At occurrence count raise run request if trigger flag or last mark set.
// - At occurrence count advance unless state marked last or already the final state.
// - Else match without hit clears counter and jumps to the branch target.
// - State word: occurrence count in bits 15:0, branch target in bits 23:20.
// - State word bits 24-25 stop, 26-27 clear, 28-29 start timers one and two.
// - Bit 30 is trigger flag, bit 31 last mark; state chain number 0 to 15.
package tss_pkg;
    localparam int NUM_STATES = 16;
    localparam int TREES_PER_STATE = 3;
    localparam int WORDS_PER_TREE = 6;
    localparam int TREE_BITS = 192;
    localparam int SEL_WIDTH = 8;
    localparam int STATE_ID_WIDTH = 4;
    localparam int TREE_HIT = 0;
    localparam int TREE_ELSE = 1;
    localparam int TREE_CAPTURE = 2;
    localparam logic [7:0] STATE_CHAIN_BASE = 8'h00;
    localparam logic [7:0] SUM_CHAIN_BASE = 8'h40;
    localparam int MATCH_TOTAL_LSB = 0;
    localparam int MATCH_TOTAL_WIDTH = 16;
    localparam int BRANCH_FIELD_POSITION = 20;
    localparam int STOP_TIMER_LSB = 24;
    localparam int CLEAR_TIMER_LSB = 26;
    localparam int START_TIMER_LSB = 28;
    localparam int FIRE_REQUEST_BIT = 30;
    localparam int FINAL_STAGE_BIT = 31;
    localparam logic [31:0] STATE_WORD_RESET = 32'h0000_0000;
    localparam logic [31:0] TREE_WORD_RESET = 32'h0000_0000;
    localparam int FINAL_WORD = 0;
    localparam int MID_WORD = 1;
    localparam int PAIR_WORD_LAST = 5;
endpackage

//--- hw/tss_sum_tree.sv
`timescale 1ns/1ns
module tss_sum_tree (
    input wire logic [tss_pkg::TREE_BITS-1:0] tree_cfg,
    input wire logic [19:0] term_result,
    input wire logic [1:0] window_check_one,
    input wire logic [1:0] window_check_two,
    input wire logic transition_check_one,
    input wire logic transition_check_two,
    input wire logic timer_one_hit,
    input wire logic timer_two_hit,
    output logic match
);
    logic [31:0] mid_word;
    logic [31:0] fin_word;
    logic [3:0] pair_idx [8];
    logic [7:0] pair_out;
    logic [15:0] mid_one_table;
    logic [15:0] mid_two_table;
    logic [3:0] final_table;
    logic mid_one;
    logic mid_two;

    // Tables are plain memories indexed by their inputs, so any function fits.
    function automatic logic lut16(input logic [15:0] table_bits, input logic [3:0] idx);
        return table_bits[idx];
    endfunction

    function automatic logic [31:0] cfg_word(input logic [tss_pkg::TREE_BITS-1:0] cfg,
                                             input int n);
        return cfg[tss_pkg::TREE_BITS-1-32*n -: 32];
    endfunction

    // Index is {B1,B0,A1,A0}; single hits are copied onto both B inputs.
    always_comb begin
        pair_idx[0] = {term_result[3:2], term_result[1:0]};
        pair_idx[1] = {window_check_one, term_result[5:4]};
        pair_idx[2] = {{2{transition_check_one}}, term_result[7:6]};
        pair_idx[3] = {{2{timer_one_hit}}, term_result[9:8]};
        pair_idx[4] = {term_result[13:12], term_result[11:10]};
        pair_idx[5] = {window_check_two, term_result[15:14]};
        pair_idx[6] = {{2{transition_check_two}}, term_result[17:16]};
        pair_idx[7] = {{2{timer_two_hit}}, term_result[19:18]};
    end

    // Inversion lives only in these table contents; there is no invert control.
    genvar k;
    generate
        for (k = 0; k < 8; k++) begin : g_pair
            logic [31:0] w;
            assign w = cfg_word(tree_cfg, tss_pkg::PAIR_WORD_LAST - k / 2);
            assign pair_out[k] = lut16((k % 2 == 1) ? w[31:16] : w[15:0], pair_idx[k]);
        end
    endgenerate

    assign mid_word = cfg_word(tree_cfg, tss_pkg::MID_WORD);
    assign fin_word = cfg_word(tree_cfg, tss_pkg::FINAL_WORD);
    assign mid_one_table = mid_word[31:16];
    assign mid_two_table = mid_word[15:0];
    assign final_table = fin_word[3:0];
    assign mid_one = lut16(mid_one_table, pair_out[3:0]);
    assign mid_two = lut16(mid_two_table, pair_out[7:4]);
    assign match = final_table[{mid_two, mid_one}];
endmodule

//--- hw/tss_sequencer.sv
`timescale 1ns/1ns
module tss_sequencer #(
    parameter int OCC_WIDTH = 16
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CFG_SELECT,
    input wire logic CFG_WRITE,
    input wire logic [31:0] CFG_DATA,
    input wire logic ARM,
    input wire logic SAMPLE_VALID,
    input wire logic [19:0] TERM_RESULT,
    input wire logic [1:0] WINDOW_CHECK_ONE,
    input wire logic [1:0] WINDOW_CHECK_TWO,
    input wire logic TRANSITION_CHECK_ONE,
    input wire logic TRANSITION_CHECK_TWO,
    input wire logic TIMER_ONE_HIT,
    input wire logic TIMER_TWO_HIT,
    output logic CAPTURE_STROBE,
    output logic RUN_REQUEST,
    output logic [1:0] TIMER_START,
    output logic [1:0] TIMER_STOP,
    output logic [1:0] TIMER_CLEAR,
    output logic [3:0] CURRENT_STATE
);
    localparam int NS = tss_pkg::NUM_STATES;
    localparam int NT = tss_pkg::TREES_PER_STATE;
    localparam int NW = tss_pkg::WORDS_PER_TREE;

    // The counter must hold every occurrence count the state word can express.
    if (OCC_WIDTH < tss_pkg::MATCH_TOTAL_WIDTH || OCC_WIDTH > 32) begin : g_bad_width
        $error("OCC_WIDTH must lie between 16 and 32");
    end

    logic [31:0] state_word_ff [NS];
    logic [31:0] tree_word_ff [NS][NT][NW];
    logic [7:0] sel_ff;
    logic [2:0] wr_idx_ff;
    logic [3:0] state_ff;
    logic [3:0] nxt_state;
    logic [OCC_WIDTH-1:0] hit_cnt_ff;
    logic [OCC_WIDTH-1:0] nxt_hit_cnt;
    logic [OCC_WIDTH-1:0] cnt_inc;
    logic capture_ff;
    logic nxt_capture;
    logic run_ff;
    logic fire;
    logic reach;
    logic [1:0] start_ff;
    logic [1:0] stop_ff;
    logic [1:0] clear_ff;
    logic [tss_pkg::TREE_BITS-1:0] tree_cfg [NT];
    logic [NT-1:0] tree_match;
    logic [31:0] cur_word;
    logic [OCC_WIDTH-1:0] occ_target;
    logic [3:0] branch_target;
    logic is_last;
    logic hit_m;
    logic else_m;
    logic cap_m;

    function automatic logic is_state_chain(input logic [7:0] sel);
        return sel[7:4] == tss_pkg::STATE_CHAIN_BASE[7:4];
    endfunction

    function automatic logic is_sum_chain(input logic [7:0] sel);
        return sel[7:6] == tss_pkg::SUM_CHAIN_BASE[7:6] && sel[1:0] != 2'h3;
    endfunction

    // Select resets the word position so each chain reload starts afresh.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sel_ff <= 8'hFF;
            wr_idx_ff <= 3'h0;
        end else if (CFG_SELECT) begin
            sel_ff <= CFG_DATA[7:0];
            wr_idx_ff <= 3'h0;
        end else if (CFG_WRITE && wr_idx_ff < 3'(NW)) begin
            wr_idx_ff <= wr_idx_ff + 3'h1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            for (int s = 0; s < NS; s++) begin
                state_word_ff[s] <= tss_pkg::STATE_WORD_RESET;
            end
        end else if (CFG_WRITE && !CFG_SELECT && is_state_chain(sel_ff)) begin
            state_word_ff[sel_ff[3:0]] <= CFG_DATA;
        end
    end

    // Words beyond the sixth of a sum chain are dropped.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            for (int s = 0; s < NS; s++) begin
                for (int t = 0; t < NT; t++) begin
                    for (int w = 0; w < NW; w++) begin
                        tree_word_ff[s][t][w] <= tss_pkg::TREE_WORD_RESET;
                    end
                end
            end
        end else if (CFG_WRITE && !CFG_SELECT && is_sum_chain(sel_ff) && wr_idx_ff < 3'(NW)) begin
            tree_word_ff[sel_ff[5:2]][sel_ff[1:0]][wr_idx_ff] <= CFG_DATA;
        end
    end

    // Only the current state's trees are evaluated, trading a wide mux for 45 idle trees.
    always_comb begin
        for (int t = 0; t < NT; t++) begin
            for (int w = 0; w < NW; w++) begin
                tree_cfg[t][tss_pkg::TREE_BITS-1-32*w -: 32] = tree_word_ff[state_ff][t][w];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NT; g++) begin : g_tree
            tss_sum_tree tss_sum_tree_i (
                .tree_cfg(tree_cfg[g]),
                .term_result(TERM_RESULT),
                .window_check_one(WINDOW_CHECK_ONE),
                .window_check_two(WINDOW_CHECK_TWO),
                .transition_check_one(TRANSITION_CHECK_ONE),
                .transition_check_two(TRANSITION_CHECK_TWO),
                .timer_one_hit(TIMER_ONE_HIT),
                .timer_two_hit(TIMER_TWO_HIT),
                .match(tree_match[g])
            );
        end
    endgenerate

    assign hit_m = tree_match[tss_pkg::TREE_HIT];
    assign else_m = tree_match[tss_pkg::TREE_ELSE];
    assign cap_m = tree_match[tss_pkg::TREE_CAPTURE];
    assign cur_word = state_word_ff[state_ff];
    assign occ_target = OCC_WIDTH'(cur_word[tss_pkg::MATCH_TOTAL_LSB +: tss_pkg::MATCH_TOTAL_WIDTH]);
    assign branch_target = cur_word[tss_pkg::BRANCH_FIELD_POSITION +: 4];
    assign is_last = cur_word[tss_pkg::FINAL_STAGE_BIT];
    assign cnt_inc = hit_cnt_ff + OCC_WIDTH'(1);
    assign reach = !ARM && SAMPLE_VALID && hit_m && cnt_inc == occ_target;

    always_comb begin
        nxt_state = state_ff;
        nxt_hit_cnt = hit_cnt_ff;
        nxt_capture = 1'b0;
        fire = 1'b0;
        if (ARM) begin
            nxt_state = 4'h0;
            nxt_hit_cnt = '0;
        end else if (SAMPLE_VALID) begin
            nxt_capture = cap_m;
            if (hit_m) begin
                nxt_hit_cnt = cnt_inc;
                if (reach) begin
                    nxt_hit_cnt = '0;
                    fire = cur_word[tss_pkg::FIRE_REQUEST_BIT] || is_last;
                    if (!is_last && state_ff != 4'(NS - 1)) begin
                        nxt_state = state_ff + 4'h1;
                    end
                end
            end else if (else_m) begin
                nxt_hit_cnt = '0;
                nxt_state = branch_target;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_ff <= 4'h0;
            hit_cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            hit_cnt_ff <= nxt_hit_cnt;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            capture_ff <= 1'b0;
        end else begin
            capture_ff <= nxt_capture;
        end
    end

    // Fire outranks ARM here, but fire is never raised while ARM is high, so a match in the arming cycle is lost.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            run_ff <= 1'b0;
        end else if (fire) begin
            run_ff <= 1'b1;
        end else if (ARM) begin
            run_ff <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            start_ff <= 2'h0;
            stop_ff <= 2'h0;
            clear_ff <= 2'h0;
        end else begin
            start_ff <= reach ? cur_word[tss_pkg::START_TIMER_LSB +: 2] : 2'h0;
            stop_ff <= reach ? cur_word[tss_pkg::STOP_TIMER_LSB +: 2] : 2'h0;
            clear_ff <= reach ? cur_word[tss_pkg::CLEAR_TIMER_LSB +: 2] : 2'h0;
        end
    end

    assign CAPTURE_STROBE = capture_ff;
    assign RUN_REQUEST = run_ff;
    assign TIMER_START = start_ff;
    assign TIMER_STOP = stop_ff;
    assign TIMER_CLEAR = clear_ff;
    assign CURRENT_STATE = state_ff;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    a_capture_on_match: assert property (
        SAMPLE_VALID && !ARM && cap_m |=> CAPTURE_STROBE)
        else $error("capture match did not store the sample");
    a_capture_needs_valid: assert property (
        !SAMPLE_VALID && !ARM |=> !CAPTURE_STROBE && $stable(state_ff) && $stable(hit_cnt_ff))
        else $error("sequencer acted on an invalid sample");
    a_hit_counting: assert property (
        SAMPLE_VALID && !ARM && hit_m && !reach |=> hit_cnt_ff == $past(hit_cnt_ff) + 1'b1)
        else $error("hit counter did not advance by one");
    a_reach_timers: assert property (
        reach |=> TIMER_START == $past(cur_word[29:28]) && TIMER_STOP == $past(cur_word[25:24])
                  && TIMER_CLEAR == $past(cur_word[27:26]) && hit_cnt_ff == '0
                  ##1 (TIMER_START == 2'h0 || $past(reach)))
        else $error("timer actions wrong at occurrence count");
    a_fire_request: assert property (
        reach && (cur_word[30] || cur_word[31]) |=> RUN_REQUEST ##1 (RUN_REQUEST || $past(ARM)))
        else $error("run request missing after firing state");
    a_advance_state: assert property (
        reach && !cur_word[31] && state_ff != 4'hF |=> state_ff == $past(state_ff) + 4'h1)
        else $error("sequencer failed to advance");
    a_hold_final: assert property (
        reach && (cur_word[31] || state_ff == 4'hF) |=> $stable(state_ff))
        else $error("sequencer advanced past a final stage");
    a_else_branch: assert property (
        SAMPLE_VALID && !ARM && !hit_m && else_m |=> state_ff == $past(cur_word[23:20])
        && hit_cnt_ff == '0)
        else $error("else branch taken incorrectly");
    a_arm_restart: assert property (
        ARM && !fire |=> state_ff == 4'h0 && hit_cnt_ff == '0 && !RUN_REQUEST)
        else $error("arming did not restart the sequencer");
    a_final_constant: assert property (
        tree_cfg[tss_pkg::TREE_HIT][163:160] == 4'h0 |-> !hit_m)
        else $error("all-zero final table produced a match");
    a_state_word_load: assert property (
        CFG_WRITE && !CFG_SELECT && sel_ff < 8'h10 |=> state_word_ff[$past(sel_ff[3:0])]
        == $past(CFG_DATA))
        else $error("state word not stored");

    c_advance: cover property (reach && state_ff != 4'hF ##1 state_ff != 4'h0);
    c_branch: cover property (SAMPLE_VALID && !hit_m && else_m);
    c_run: cover property (!RUN_REQUEST ##1 RUN_REQUEST);
    c_capture: cover property (CAPTURE_STROBE [*3]);
endmodule

//--- testbench/tss_host_model.sv
`timescale 1ns/1ns
module tss_host_model (
    input wire logic clk,
    output logic cfg_select,
    output logic cfg_write,
    output logic [31:0] cfg_data,
    input wire logic capture_strobe
);
    // Pair codes by operation: nop, any, and, nand, or, nor, xor, equivalence_gate, a, b.
    logic [15:0] pair_tab [10] = '{16'h0000, 16'hFFFF, 16'h8000, 16'h7FFF, 16'hF888,
        16'h0777, 16'h7888, 16'h8777, 16'h8888, 16'hF000};
    logic [15:0] mid_tab [8] = '{16'h0000, 16'hFFFF, 16'h8000, 16'h7FFF, 16'hFFFE,
        16'h0001, 16'h0116, 16'hEEEE};
    logic [3:0] fin_tab [8] = '{4'h0, 4'hF, 4'h8, 4'h7, 4'hE, 4'h1, 4'h6, 4'h9};
    logic [31:0] n_captured = 32'h0000_0000;

    initial begin
        cfg_select = 1'b0;
        cfg_write = 1'b0;
        cfg_data = 32'h0000_0000;
    end

    // The capture path only counts strobes here; the stored sample lives elsewhere.
    always @(posedge clk) begin
        if (capture_strobe === 1'b1) begin
            n_captured <= n_captured + 32'h0000_0001;
        end
    end

    // An idle data bus shows the inverse of its last value, so stale data cannot pass.
    task automatic drive(input logic sel, input logic wr, input logic [31:0] d);
        cfg_select = sel;
        cfg_write = wr;
        cfg_data = (sel | wr) ? d : ~cfg_data;
    endtask

    // Only nibbles 7 and 8 flip on the first input, which holds for the standard codes.
    function automatic logic [15:0] pair_code(input int op, input logic ia, input logic ib);
        logic [15:0] v;
        v = pair_tab[op];
        for (int n = 0; n < 4; n++) begin
            if (ia && v[4*n+:4] == 4'h7) v[4*n+:4] = 4'h8;
            else if (ia && v[4*n+:4] == 4'h8) v[4*n+:4] = 4'h7;
        end
        if (ib) v = {v[3:0], v[15:12], v[15:12], v[15:12]};
        return v;
    endfunction
endmodule

//--- testbench/tb_trigger_sum_sequencer.sv
`timescale 1ns/1ns
module tb_trigger_sum_sequencer;
    logic clk, rst_n, arm, sample_valid, cfg_select, cfg_write, capture_strobe, run_request;
    logic [31:0] cfg_data, seed, r;
    logic [27:0] det;
    logic [1:0] timer_start, timer_stop, timer_clear;
    logic [3:0] current_state, m_state;
    logic [31:0] sw [16];
    logic [5:0][31:0] tw [16][3];
    logic [15:0] m_cnt;
    logic [7:0] m_sel;
    logic m_run;
    logic [11:0] notes [$];
    int m_widx, n_caps = 0, n_errors = 0, n_tests = 0;

    tss_host_model tss_host_model_i (.clk(clk), .cfg_select(cfg_select),
        .cfg_write(cfg_write), .cfg_data(cfg_data), .capture_strobe(capture_strobe));
    tss_sequencer #(.OCC_WIDTH(16)) tss_sequencer_i (.CLK(clk), .RST_N(rst_n),
        .CFG_SELECT(cfg_select), .CFG_WRITE(cfg_write), .CFG_DATA(cfg_data), .ARM(arm),
        .SAMPLE_VALID(sample_valid), .TERM_RESULT(det[19:0]), .WINDOW_CHECK_ONE(det[21:20]),
        .WINDOW_CHECK_TWO(det[23:22]), .TRANSITION_CHECK_ONE(det[24]),
        .TRANSITION_CHECK_TWO(det[25]), .TIMER_ONE_HIT(det[26]), .TIMER_TWO_HIT(det[27]),
        .CAPTURE_STROBE(capture_strobe), .RUN_REQUEST(run_request), .TIMER_START(timer_start),
        .TIMER_STOP(timer_stop), .TIMER_CLEAR(timer_clear), .CURRENT_STATE(current_state));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic lu(input logic [15:0] t, input logic [3:0] i);
        return t[i];
    endfunction

    // Reference sum tree: pair index is {B1,B0,A1,A0}, final index is {mid2,mid1}.
    function automatic logic ev(input logic [5:0][31:0] w, input logic [27:0] x);
        logic [7:0] p;
        logic [1:0] m;
        p[0] = lu(w[5][15:0], x[3:0]);
        p[1] = lu(w[5][31:16], {x[21:20], x[5:4]});
        p[2] = lu(w[4][15:0], {x[24], x[24], x[7:6]});
        p[3] = lu(w[4][31:16], {x[26], x[26], x[9:8]});
        p[4] = lu(w[3][15:0], x[13:10]);
        p[5] = lu(w[3][31:16], {x[23:22], x[15:14]});
        p[6] = lu(w[2][15:0], {x[25], x[25], x[17:16]});
        p[7] = lu(w[2][31:16], {x[27], x[27], x[19:18]});
        m[0] = lu(w[1][31:16], p[3:0]);
        m[1] = lu(w[1][15:0], p[7:4]);
        return w[0][m];
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want) begin
            n_errors++;
            $display("FAIL at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask

    // One cycle of stimulus; the model notes the outputs expected after the next edge.
    task automatic cyc(input logic sel, input logic wr, input logic [31:0] d,
                       input logic a, input logic vld, input logic [27:0] x);
        logic [11:0] e;
        logic [31:0] s;
        @(negedge clk);
        tss_host_model_i.drive(sel, wr, d);
        arm = a;
        sample_valid = vld;
        det = x;
        s = sw[m_state];
        e = 12'h000;
        if (a) begin
            m_state = 4'h0;
            m_cnt = 16'h0000;
            m_run = 1'b0;
        end else if (vld) begin
            e[11] = ev(tw[m_state][2], x);
            if (ev(tw[m_state][0], x)) begin
                if (m_cnt + 16'h0001 == s[15:0]) begin
                    e[9:4] = {s[29:28], s[25:24], s[27:26]};
                    m_cnt = 16'h0000;
                    m_run = m_run | s[30] | s[31];
                    if (!s[31] && m_state != 4'hF) m_state++;
                end else m_cnt++;
            end else if (ev(tw[m_state][1], x)) begin
                m_cnt = 16'h0000;
                m_state = s[23:20];
            end
        end
        if (sel) begin
            m_sel = d[7:0];
            m_widx = 0;
        end else if (wr && m_sel < 8'h10) begin
            sw[m_sel[3:0]] = d;
        end else if (wr && m_sel[7:6] == 2'b01 && m_sel[1:0] != 2'b11 && m_widx < 6) begin
            tw[m_sel[5:2]][m_sel[1:0]][m_widx] = d;
            m_widx++;
        end
        e[10] = m_run;
        e[3:0] = m_state;
        n_caps += e[11];
        notes.push_back(e);
    endtask

    task automatic do_reset();
        @(negedge clk);
        rst_n = 1'b0;
        tss_host_model_i.drive(1'b0, 1'b0, 32'h0000_0000);
        sample_valid = 1'b0;
        arm = 1'b0;
        repeat (4) begin
            notes.push_back(12'h000);
            @(negedge clk);
        end
        rst_n = 1'b1;
        {m_state, m_cnt, m_run, m_sel, m_widx} = '0;
        sw = '{default: '0};
        tw = '{default: '0};
        notes.push_back(12'h000);
        $display("reset test done");
    endtask

    // Seven words go to every tree; the seventh must be dropped.
    task automatic put_tree(input logic [7:0] chain, input logic raw);
        logic [31:0] w;
        cyc(1'b1, 1'b0, {24'h000000, chain}, 1'b0, 1'b0, 28'h0000000);
        for (int k = 0; k < 7; k++) begin
            w = $random(seed);
            if (!raw && k == 0) w = {28'h0000000, tss_host_model_i.fin_tab[w[2:0]]};
            else if (!raw && k == 1) w = {tss_host_model_i.mid_tab[w[2:0]],
                tss_host_model_i.mid_tab[w[6:4]]};
            else if (!raw) w = {tss_host_model_i.pair_code(w[3:0] % 10, w[4], w[5]),
                tss_host_model_i.pair_code(w[11:8] % 10, w[12], w[13])};
            cyc(1'b0, 1'b1, w, 1'b0, 1'b0, 28'h0000000);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        forever begin
            @(posedge clk);
            #1;
            if (notes.size() > 0) check({capture_strobe, run_request, timer_start, timer_stop,
                timer_clear, current_state}, notes.pop_front());
        end
    end

    initial begin
        #40000;
        n_errors++;
        $display("FAIL at %0t: watchdog expired", $time);
        give_verdict();
    end

    initial begin
        seed = 32'h31AB210F;
        {rst_n, arm, sample_valid, det} = '0;
        do_reset();
        check(tss_host_model_i.pair_code(5, 1'b0, 1'b0), 32'h0000_0777);
        check(tss_host_model_i.pair_code(4, 1'b1, 1'b0), 32'h0000_F777);
        check(tss_host_model_i.pair_code(4, 1'b0, 1'b1), 32'h0000_8FFF);
        check(tss_host_model_i.pair_code(5, 1'b1, 1'b1), 32'h0000_8000);
        // State 5 leaves by its else tree to 12; only state 15 fires.
        for (int s = 0; s < 16; s++) begin
            cyc(1'b1, 1'b0, 32'(s), 1'b0, 1'b0, 28'h0000000);
            cyc(1'b0, 1'b1, {1'b0, s == 15, 6'(s * 5), (s == 5) ? 4'hC : 4'h0, 4'h0,
                16'(1 + (s == 0))}, 1'b0, 1'b0, 28'h0000000);
            cyc(1'b1, 1'b0, 32'(8'h40 + 8'(4 * s + (s == 5))), 1'b0, 1'b0, 28'h0000000);
            cyc(1'b0, 1'b1, 32'h0000_000F, 1'b0, 1'b0, 28'h0000000);
        end
        cyc(1'b1, 1'b1, 32'h0000_0043, 1'b0, 1'b0, 28'h0000000);
        cyc(1'b0, 1'b1, 32'hFFFF_FFFF, 1'b0, 1'b0, 28'h0000000);
        for (int i = 0; i < 24; i++) cyc(1'b0, 1'b0, 32'h0, 1'b0, i % 4 != 3, 28'($random(seed)));
        cyc(1'b0, 1'b0, 32'h0, 1'b1, 1'b1, 28'hFFFFFFF);
        $display("walk test done");
        do_reset();
        for (int i = 0; i < 4; i++) cyc(1'b0, 1'b0, 32'h0, 1'b0, 1'b1, 28'hFFFFFFF);
        repeat (2) begin
            for (int s = 0; s < 16; s++) begin
                r = $random(seed);
                cyc(1'b1, 1'b0, 32'(s), 1'b0, 1'b0, 28'h0000000);
                cyc(1'b0, 1'b1, {r[31:20], 4'h0, 16'(r[1:0]) + 16'h0001}, 1'b0, 1'b0, 28'h0);
                for (int t = 0; t < 3; t++) put_tree(8'h40 + 8'(4 * s + t), r[5]);
            end
            for (int i = 0; i < 300; i++) begin
                r = $random(seed);
                cyc(1'b0, 1'b0, 32'h0, r[31:28] == 4'h0, r[27:26] != 2'b00, 28'($random(seed)));
            end
            $display("random test done");
        end
        cyc(1'b0, 1'b0, 32'h0, 1'b0, 1'b0, 28'h0000000);
        cyc(1'b0, 1'b0, 32'h0, 1'b0, 1'b0, 28'h0000000);
        @(posedge clk);
        #2;
        check(tss_host_model_i.n_captured, n_caps);
        give_verdict();
    end
endmodule
